// [src/flash_selfprog_pkg.sv]
`default_nettype none
package flash_selfprog_pkg;
   // ==========================================
   // Control/status bit positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_ERASE = 1;
   localparam int BIT_WRITE = 2;
   localparam int BIT_LOCKSET = 3;
   localparam int BIT_REENABLE = 4;
   localparam int BIT_BUSY = 6;
   localparam int BIT_IRQ_EN = 7;
   // ==========================================
   // Command codes in bits 5:0 (bit 6 read only, bit 7 interrupt enable)
   localparam logic [5:0] CMD_LOAD = 6'h01;
   localparam logic [5:0] CMD_ERASE = 6'h03;
   localparam logic [5:0] CMD_WRITE = 6'h05;
   localparam logic [5:0] CMD_LOCK = 6'h09;
   localparam logic [5:0] CMD_REENABLE = 6'h11;
   // ==========================================
   // Reset values and timing
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] LOCK_RESET = 8'hff;
   localparam int STORE_WINDOW_CYCLES = 4;
   localparam int CLOCK_PERIOD_NS = 5;
   localparam int PROG_TIME_US = 3700;
   localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLOCK_PERIOD_NS;
   localparam logic [5:0] LOCK_FIELD_MASK = 6'h3f;
endpackage
`default_nettype wire

// [src/flash_self_programming_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_self_programming_ctrl #(
   parameter int PAGE_WORD_BITS = 7,
   parameter int PTR_BITS = 24,
   parameter int RWW_PAGE_LIMIT = 1920,
   parameter int PROG_COUNT = flash_selfprog_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Control/status register port
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   output logic [7:0] ctrl_rdata,
   // Store instruction with pointer and data pair
   input wire logic store_instr,
   input wire logic [7:0] flash_pointer_low,
   input wire logic [7:0] flash_pointer_high,
   input wire logic [7:0] flash_addr_ext_byte,
   input wire logic [15:0] data_pair,
   // EEPROM write in progress (asynchronous)
   input wire logic eeprom_prog_enable,
   // Load byte instruction read address
   input wire logic load_program_byte_instr,
   output logic [PTR_BITS-2:0] read_word_addr,
   output logic pointer_byte_select,
   output logic rww_read_blocked,
   // Flash array side
   output logic array_erase,
   output logic array_write,
   output logic [PTR_BITS-PAGE_WORD_BITS-2:0] page_address_field,
   output logic [15:0] buf_rdata,
   input wire logic [PAGE_WORD_BITS-1:0] buf_raddr,
   output logic [7:0] lock_bits,
   output logic cpu_halt,
   output logic irq
);
   import flash_selfprog_pkg::*;
   localparam int WORDS = 1 << PAGE_WORD_BITS;
   localparam int PGW = PTR_BITS - PAGE_WORD_BITS - 1;
   localparam int CW = $clog2(PROG_COUNT + 1);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_ARMED = 4'b0010, ST_BUSY = 4'b0100, ST_DONE = 4'b1000
   } state_type;

   // ==========================================
   // EEPROM busy synchroniser
   logic ee_m_q, ee_s_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ee_m_q <= 1'b0;
         ee_s_q <= 1'b0;
      end else begin
         ee_m_q <= eeprom_prog_enable;
         ee_s_q <= ee_m_q;
      end
   end

   // ==========================================
   // Sequencer state
   state_type st_q, st_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [2:0] win_q, win_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [PGW-1:0] page_q, page_d;
   logic [5:0] opcmd_q, opcmd_d;
   logic busy_q, busy_d;
   logic halt_q, halt_d;
   logic erase_q, erase_d, write_q, write_d;
   logic [7:0] lock_q, lock_d;
   logic [7:0] lock_wdata_q, lock_wdata_d;
   logic buf_clear;
   logic buf_load;
   logic [PTR_BITS-1:0] ptr;
   logic [PGW-1:0] ptr_page;
   logic [PAGE_WORD_BITS-1:0] ptr_word;

   // Pointer assembly; extension byte only counts when the space needs it
   assign ptr = PTR_BITS'({flash_addr_ext_byte, flash_pointer_high, flash_pointer_low});
   assign ptr_page = ptr[PTR_BITS-1:PAGE_WORD_BITS+1];
   assign ptr_word = ptr[PAGE_WORD_BITS:1];

   // Next-state logic for command, window and running operation
   always_comb begin
      st_d = st_q;
      ctrl_d = ctrl_q;
      win_d = win_q;
      cnt_d = cnt_q;
      page_d = page_q;
      opcmd_d = opcmd_q;
      busy_d = busy_q;
      halt_d = halt_q;
      erase_d = 1'b0;
      write_d = 1'b0;
      lock_d = lock_q;
      lock_wdata_d = lock_wdata_q;
      buf_clear = 1'b0;
      buf_load = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            // EEPROM write blocks new commands; the interrupt enable bit is still written
            if (ctrl_wr && !ee_s_q && ctrl_wdata[BIT_ENABLE]) begin
               ctrl_d[5:0] = ctrl_wdata[5:0];
               win_d = 3'(STORE_WINDOW_CYCLES);
               st_d = ST_ARMED;
            end
            if (ctrl_wr) begin
               ctrl_d[BIT_IRQ_EN] = ctrl_wdata[BIT_IRQ_EN];
            end
         end
         ST_ARMED: begin
            if (store_instr) begin
               unique case (ctrl_q[5:0])
                  CMD_LOAD: begin
                     buf_load = 1'b1;
                     ctrl_d[5:0] = 6'h00;
                     st_d = ST_IDLE;
                  end
                  CMD_REENABLE: begin
                     buf_clear = 1'b1;
                     busy_d = 1'b0;
                     ctrl_d[5:0] = 6'h00;
                     st_d = ST_IDLE;
                  end
                  CMD_ERASE, CMD_WRITE, CMD_LOCK: begin
                     // Latch the page so the pointer is free afterwards
                     page_d = ptr_page;
                     opcmd_d = ctrl_q[5:0];
                     lock_wdata_d = data_pair[7:0];
                     cnt_d = CW'(PROG_COUNT);
                     if (ctrl_q[5:0] != CMD_LOCK) begin
                        busy_d = 1'b1;
                        halt_d = (32'(ptr_page) >= RWW_PAGE_LIMIT);
                     end
                     erase_d = (ctrl_q[5:0] == CMD_ERASE);
                     write_d = (ctrl_q[5:0] == CMD_WRITE);
                     st_d = ST_BUSY;
                  end
                  default: begin
                     ctrl_d[5:0] = 6'h00;
                     st_d = ST_IDLE;
                  end
               endcase
            end else if (win_q <= 3'h1) begin
               ctrl_d[5:0] = 6'h00;
               st_d = ST_IDLE;
            end else begin
               win_d = win_q - 3'h1;
            end
         end
         ST_BUSY: begin
            // Enable bit held until the timer runs out
            if (cnt_q <= CW'(1)) begin
               st_d = ST_DONE;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         ST_DONE: begin
            if (opcmd_q == CMD_LOCK) begin
               // Only zeros in 5:0 program; programmed bits hold until reset
               lock_d[5:0] = lock_q[5:0] & (lock_wdata_q[5:0] | ~LOCK_FIELD_MASK);
            end
            if (opcmd_q == CMD_WRITE) begin
               buf_clear = 1'b1;
            end
            halt_d = 1'b0;
            ctrl_d[5:0] = 6'h00;
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
         ctrl_q <= CTRL_RESET;
         win_q <= 3'h0;
         cnt_q <= '0;
         page_q <= '0;
         opcmd_q <= 6'h00;
         busy_q <= 1'b0;
         halt_q <= 1'b0;
         erase_q <= 1'b0;
         write_q <= 1'b0;
         lock_q <= LOCK_RESET;
         lock_wdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         ctrl_q <= ctrl_d;
         win_q <= win_d;
         cnt_q <= cnt_d;
         page_q <= page_d;
         opcmd_q <= opcmd_d;
         busy_q <= busy_d;
         halt_q <= halt_d;
         erase_q <= erase_d;
         write_q <= write_d;
         lock_q <= lock_d;
         lock_wdata_q <= lock_wdata_d;
      end
   end

   // ==========================================
   // Temporary page buffer; EEPROM activity never touches it
   logic [15:0] buf_mem [WORDS];
   logic [WORDS-1:0] buf_valid_q, buf_valid_d;
   logic [15:0] buf_rdata_q;
   always_comb begin
      buf_valid_d = buf_valid_q;
      if (buf_clear) begin
         buf_valid_d = '0;
      end else if (buf_load) begin
         buf_valid_d[ptr_word] = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         buf_valid_q <= '0;
      end else begin
         buf_valid_q <= buf_valid_d;
      end
   end
   // Storage without reset; cleared words read as erased ones
   always_ff @(posedge clock) begin
      if (buf_load) begin
         buf_mem[ptr_word] <= data_pair;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         buf_rdata_q <= 16'hffff;
      end else begin
         buf_rdata_q <= buf_valid_q[buf_raddr] ? buf_mem[buf_raddr] : 16'hffff;
      end
   end

   // ==========================================
   // Registered outputs
   logic irq_q, blk_q, bsel_q;
   logic [PTR_BITS-2:0] raddr_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_q <= 1'b0;
         blk_q <= 1'b0;
         bsel_q <= 1'b0;
         raddr_q <= '0;
      end else begin
         irq_q <= ctrl_d[BIT_IRQ_EN] && !ctrl_d[BIT_ENABLE];
         blk_q <= busy_d;
         if (load_program_byte_instr) begin
            bsel_q <= ptr[0];
            raddr_q <= ptr[PTR_BITS-1:1];
         end
      end
   end

   assign ctrl_rdata = {ctrl_q[7], busy_q, ctrl_q[5:0]};
   assign irq = irq_q;
   assign rww_read_blocked = blk_q;
   assign pointer_byte_select = bsel_q;
   assign read_word_addr = raddr_q;
   assign array_erase = erase_q;
   assign array_write = write_q;
   assign page_address_field = page_q;
   assign buf_rdata = buf_rdata_q;
   assign lock_bits = lock_q;
   assign cpu_halt = halt_q;

   // ==========================================
   // Checks
   a_window_expiry: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == ST_ARMED && !store_instr && win_q == 3'h1) |=> ctrl_q[5:0] == 6'h00)
      else $error("command bits did not auto-clear");
   a_eeprom_blocks: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == ST_IDLE && ee_s_q) |=> st_q == ST_IDLE)
      else $error("command accepted during eeprom write");
   a_busy_blocks: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == ST_BUSY && opcmd_q != CMD_LOCK) |-> rww_read_blocked && busy_q)
      else $error("rww reads not blocked while busy");
   a_irq_level: assert property (@(posedge clock) disable iff (!rstn)
      (ctrl_q[BIT_IRQ_EN] && !ctrl_q[BIT_ENABLE]) |-> irq)
      else $error("interrupt missing while enable clear");
   a_enable_held: assert property (@(posedge clock) disable iff (!rstn)
      st_q == ST_BUSY |-> ctrl_q[BIT_ENABLE])
      else $error("enable bit dropped during operation");
   a_lock_nohalt: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == ST_BUSY && opcmd_q == CMD_LOCK) |-> !cpu_halt && !busy_q)
      else $error("lock programming halted cpu");
   a_page_latched: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == ST_BUSY && $past(st_q) == ST_BUSY) |-> $stable(page_q))
      else $error("latched page changed");
   a_write_clears: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == ST_DONE && opcmd_q == CMD_WRITE) |=> buf_valid_q == '0)
      else $error("buffer not cleared after write");
endmodule // flash_self_programming_ctrl
`default_nettype wire

// [tb/cpu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// CPU core: command register writes, store and byte-read instructions
module cpu_core_model (
   // Clock
   input wire logic clock,
   // Control register and instructions
   output logic ctrl_wr,
   output logic [7:0] ctrl_wdata,
   input wire logic [7:0] ctrl_rdata,
   output logic store_instr,
   output logic load_program_byte_instr,
   // Pointer bytes and register pair, held like register file contents
   output logic [7:0] flash_pointer_low,
   output logic [7:0] flash_pointer_high,
   output logic [7:0] flash_addr_ext_byte,
   output logic [15:0] data_pair
);
   // Idle values from time zero
   initial begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 8'h00;
      store_instr = 1'b0;
      load_program_byte_instr = 1'b0;
      {flash_addr_ext_byte, flash_pointer_high, flash_pointer_low} = 24'h000000;
      data_pair = 16'h0000;
   end
   // Store one edge after the command write, well inside the window
   task automatic spm(input logic [7:0] c, input logic [23:0] p, input logic [15:0] d,
      input logic st);
      @(posedge clock);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= c;
      {flash_addr_ext_byte, flash_pointer_high, flash_pointer_low} <= p;
      data_pair <= d;
      @(posedge clock);
      ctrl_wr <= 1'b0;
      store_instr <= st;
      @(posedge clock);
      store_instr <= 1'b0;
      #1;
   endtask
   // Byte read; also moves the pointer
   task automatic lpm(input logic [23:0] p);
      @(posedge clock);
      load_program_byte_instr <= 1'b1;
      {flash_addr_ext_byte, flash_pointer_high, flash_pointer_low} <= p;
      @(posedge clock);
      load_program_byte_instr <= 1'b0;
      #1;
   endtask
endmodule // cpu_core_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import flash_selfprog_pkg::*;
   logic clock, rstn, eeprom_prog_enable, ctrl_wr, store_instr, lpi;
   logic [7:0] ctrl_wdata, ctrl_rdata, p_lo, p_hi, p_ext, lock_bits;
   logic [15:0] data_pair, buf_rdata;
   logic [6:0] buf_raddr;
   logic [22:0] read_word_addr;
   logic [15:0] page_address_field;
   logic pointer_byte_select, rww_read_blocked, array_erase, array_write, cpu_halt, irq;
   int n_fail = 0;
   int checked = 0;
   int n_erase = 0;
   int n_write = 0;
   // ==========================================
   // Clock, design and CPU model
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   flash_self_programming_ctrl #(.PROG_COUNT(20)) uut (.clock(clock), .rstn(rstn),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
      .store_instr(store_instr), .flash_pointer_low(p_lo), .flash_pointer_high(p_hi),
      .flash_addr_ext_byte(p_ext), .data_pair(data_pair),
      .eeprom_prog_enable(eeprom_prog_enable), .load_program_byte_instr(lpi),
      .read_word_addr(read_word_addr), .pointer_byte_select(pointer_byte_select),
      .rww_read_blocked(rww_read_blocked), .array_erase(array_erase),
      .array_write(array_write), .page_address_field(page_address_field),
      .buf_rdata(buf_rdata), .buf_raddr(buf_raddr), .lock_bits(lock_bits),
      .cpu_halt(cpu_halt), .irq(irq));
   cpu_core_model cpu (.clock(clock), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .ctrl_rdata(ctrl_rdata), .store_instr(store_instr), .load_program_byte_instr(lpi),
      .flash_pointer_low(p_lo), .flash_pointer_high(p_hi), .flash_addr_ext_byte(p_ext),
      .data_pair(data_pair));
   // Array pulses are counted so a doubled or missing pulse shows up
   always @(posedge clock) begin
      if (array_erase === 1'b1) n_erase++;
      if (array_write === 1'b1) n_write++;
   end
   // ==========================================
   // Tasks
   task automatic summarize;
      $display("mismatches %0d of %0d compares", n_fail, checked);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Poll the enable bit with a bound, then wait one more idle cycle
   task automatic wait_idle;
      int i;
      for (i = 0; i < 200 && ctrl_rdata[BIT_ENABLE] !== 1'b0; i++) begin
         @(posedge clock);
         #1;
      end
      if (i == 200) begin
         n_fail++;
         summarize();
      end
      @(posedge clock);
      #1;
   endtask
   task automatic load(input logic [23:0] p, input logic [15:0] d);
      cpu.spm({2'b00, CMD_LOAD}, p, d, 1'b1);
      wait_idle();
   endtask
   task automatic rdbuf(input logic [6:0] a, input logic [15:0] e);
      @(posedge clock);
      buf_raddr <= a;
      repeat (2) @(posedge clock);
      #1;
      chk(buf_rdata, e);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      eeprom_prog_enable = 1'b0;
      buf_raddr = 7'h00;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      #1;
      chk(ctrl_rdata, CTRL_RESET);
      chk(lock_bits, LOCK_RESET);
      chk(irq, 1'b0);
      rdbuf(7'h03, 16'hffff);
      cpu.lpm(24'h012345);
      @(posedge clock);
      #1;
      chk(read_word_addr, 23'h0091a2);
      chk(pointer_byte_select, 1'b1);
      // Erase an application page with the interrupt enabled, pointer moved meanwhile
      cpu.spm(8'h83, 24'h000500, 16'h5555, 1'b1);
      chk(ctrl_rdata[BIT_ENABLE], 1'b1);
      cpu.lpm(24'h07ff00);
      chk(page_address_field, 16'h0005);
      chk(rww_read_blocked, 1'b1);
      chk(ctrl_rdata[BIT_BUSY], 1'b1);
      chk(cpu_halt, 1'b0);
      chk(24'(n_erase), 24'h1);
      chk(irq, 1'b0);
      wait_idle();
      chk(irq, 1'b1);
      chk(rww_read_blocked, 1'b1);
      cpu.spm({2'b00, CMD_REENABLE}, 24'h0, 16'h0, 1'b1);
      wait_idle();
      chk(ctrl_rdata[BIT_BUSY], 1'b0);
      chk(irq, 1'b0);
      // Fill out of order; an EEPROM write in between refuses a load
      load(24'h000506, 16'h1234);
      load(24'h000500, 16'habcd);
      @(posedge clock);
      eeprom_prog_enable <= 1'b1;
      repeat (3) @(posedge clock);
      load(24'h00050a, 16'h7777);
      @(posedge clock);
      eeprom_prog_enable <= 1'b0;
      repeat (3) @(posedge clock);
      rdbuf(7'h03, 16'h1234);
      rdbuf(7'h00, 16'habcd);
      rdbuf(7'h05, 16'hffff);
      // Write the same page, then erase a page in the halting section
      cpu.spm({2'b00, CMD_WRITE}, 24'h000500, 16'h9999, 1'b1);
      @(posedge clock);
      #1;
      chk(24'(n_write), 24'h1);
      chk(page_address_field, 16'h0005);
      chk(cpu_halt, 1'b0);
      wait_idle();
      rdbuf(7'h03, 16'hffff);
      cpu.spm({2'b00, CMD_ERASE}, 24'h078a00, 16'h0, 1'b1);
      @(posedge clock);
      #1;
      chk(cpu_halt, 1'b1);
      wait_idle();
      chk(cpu_halt, 1'b0);
      cpu.spm({2'b00, CMD_REENABLE}, 24'h0, 16'h0, 1'b1);
      wait_idle();
      // Lock programming: zeros program, flash stays readable
      cpu.spm({2'b00, CMD_LOCK}, 24'h000001, 16'h00fc, 1'b1);
      @(posedge clock);
      #1;
      chk({cpu_halt, rww_read_blocked}, 2'b00);
      wait_idle();
      chk(lock_bits, 8'hfc);
      // Command without a store lapses after the window
      cpu.spm({2'b00, CMD_ERASE}, 24'h000500, 16'h0, 1'b0);
      chk(ctrl_rdata[5:0], CMD_ERASE);
      repeat (STORE_WINDOW_CYCLES + 1) @(posedge clock);
      #1;
      chk(ctrl_rdata[5:0], 6'h00);
      chk(24'(n_erase), 24'h2);
      // A reset in mid-run must empty the buffer, not only the one at power-up
      load(24'h000506, 16'h4321);
      rdbuf(7'h03, 16'h4321);
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      #1;
      chk(ctrl_rdata, CTRL_RESET);
      rdbuf(7'h03, 16'hffff);
      summarize();
   end
endmodule // tb
`default_nettype wire
